//--- rac_pkg.sv
// Constants, types and the field-compare helper for the alarm-compare block.
`default_nettype none

package rac_pkg;

  typedef logic [7:0] rac_byte_t;

  localparam rac_byte_t ADDR_ALM_SUBSEC = 8'hF2;
  localparam rac_byte_t ADDR_ALM_SEC = 8'hF3;
  localparam rac_byte_t ADDR_ALM_MIN = 8'hF4;
  localparam rac_byte_t ADDR_ALM_HOUR = 8'hF5;
  localparam rac_byte_t ADDR_CTL = 8'hF9;

  localparam int SUBSEC_W = 8;
  localparam int SEC_W = 6;
  localparam int MIN_W = 6;
  localparam int HOUR_W = 5;
  localparam int WEEKDAY_LSB = 5;

  localparam int CTL_SUBSEC_EN = 7;
  localparam int CTL_SEC_EN = 6;
  localparam int CTL_MIN_EN = 5;
  localparam int CTL_HOUR_EN = 4;
  localparam int CTL_READ_FRZ = 3;
  localparam int CTL_WRITE_FRZ = 2;
  localparam int CTL_FLAG = 1;
  localparam int CTL_OSC = 0;

  // Indeterminate after a no-battery reset; zero is used so simulation stays defined.
  localparam rac_byte_t BAT_RESET_VALUE = 8'h00;
  localparam logic [3:0] EN_NONE = 4'h0;
  localparam rac_byte_t RDATA_RESET = 8'h00;
  localparam rac_byte_t RDATA_UNMAPPED = 8'h00;
  localparam rac_byte_t SUBSEC_MAX = 8'hFF;

  // A disabled field always counts as matching.
  function automatic logic rac_field_hit(
    input rac_byte_t alarm,
    input rac_byte_t now,
    input logic en
  );
    return !en || (alarm == now);
  endfunction

endpackage

`default_nettype wire

//--- rac_cmp_if.sv
// Interface carrying alarm values, clock values and the match result.
`default_nettype none

interface rac_cmp_if;
  logic [7:0] alm_subsec;
  logic [5:0] alm_sec;
  logic [5:0] alm_min;
  logic [4:0] alm_hour;
  logic [7:0] now_subsec;
  logic [5:0] now_sec;
  logic [5:0] now_min;
  logic [7:0] now_hour;
  logic [3:0] cmp_en;
  logic hit;

  modport ctl (
    output alm_subsec, alm_sec, alm_min, alm_hour,
    output now_subsec, now_sec, now_min, now_hour, cmp_en,
    input hit
  );

  modport cmp (
    input alm_subsec, alm_sec, alm_min, alm_hour,
    input now_subsec, now_sec, now_min, now_hour, cmp_en,
    output hit
  );
endinterface

`default_nettype wire

//--- rac_field_match.sv
// Combinational compare of the enabled alarm fields against the clock.
`default_nettype none

module rac_field_match (
  rac_cmp_if.cmp cmp
);
  import rac_pkg::*;

  logic hit_subsec;
  logic hit_sec;
  logic hit_min;
  logic hit_hour;

  // The full 8-bit subsecond count is compared, 00h through FFh.
  assign hit_subsec = rac_field_hit(cmp.alm_subsec, cmp.now_subsec,
                                    cmp.cmp_en[3]);
  assign hit_sec = rac_field_hit({2'b00, cmp.alm_sec}, {2'b00, cmp.now_sec},
                                 cmp.cmp_en[2]);
  assign hit_min = rac_field_hit({2'b00, cmp.alm_min}, {2'b00, cmp.now_min},
                                 cmp.cmp_en[1]);
  // Weekday bits sit above the hour and never take part.
  assign hit_hour = rac_field_hit({3'b000, cmp.alm_hour},
                                  {3'b000, cmp.now_hour[HOUR_W-1:0]},
                                  cmp.cmp_en[0]);

  // With no field enabled there is no alarm at all.
  assign cmp.hit = (cmp.cmp_en != EN_NONE) && hit_subsec && hit_sec
                   && hit_min && hit_hour;

endmodule

`default_nettype wire

//--- rac_alarm.sv
// Alarm registers, compare control and alarm flag of the real-time clock.
//
// Operation
// - Hold 8-bit subsecond alarm; its match counts only when subsecond compare enabled.
// - Hold 6-bit second alarm; its match counts only when second compare enabled.
// - Hold 6-bit minute alarm; its match counts only when minute compare enabled.
// - Hold 5-bit hour alarm; compare with hour bits when hour compare enabled.
// - Weekday bits of the hour clock never take part in comparison.
// - Alarm values survive all resets but battery loss; reserved bits stay zero.
// - Compare enables survive all resets but battery loss.
// - Subsecond disabled: alarm every subsecond tick while other enabled fields match.
// - Second disabled: seconds are don't care, alarm each second on match.
// - Minute disabled: minutes are don't care, alarm each minute on match.
// - Hour disabled: hours are don't care, alarm each hour on match.
// - Alarm condition is the AND of every enabled field match.
// - Read freeze free, write freeze and oscillator timed-access only, flag cleared by a written zero.
// - Reserved upper alarm bits always read zero.
// - Flag set on full match; requests interrupt when enabled; software clears.
// - Clearing all enables clears the flag; software can never set it.
// - Subsecond counter compared across its full 8-bit range.
`default_nettype none

module rac_alarm (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bat_rst_n,
  input wire rac_pkg::rac_byte_t sfr_addr,
  input wire logic sfr_wr,
  input wire rac_pkg::rac_byte_t sfr_wdata,
  input wire logic sfr_rd,
  input wire logic timed_access_ok,
  input wire logic [7:0] clock_subsecond,
  input wire logic [5:0] clock_second,
  input wire logic [5:0] clock_minute,
  input wire logic [7:0] clock_hour,
  input wire logic subsec_tick,
  input wire logic alarm_int_enable,
  output rac_pkg::rac_byte_t sfr_rdata_r,
  output logic alarm_flag_r,
  output logic alarm_irq_r,
  output logic read_freeze_r,
  output logic write_freeze_r,
  output logic osc_enable_r
);
  import rac_pkg::*;

  rac_byte_t alm_subsec_r;
  rac_byte_t alm_subsec_nxt;
  logic [SEC_W-1:0] alm_sec_r;
  logic [SEC_W-1:0] alm_sec_nxt;
  logic [MIN_W-1:0] alm_min_r;
  logic [MIN_W-1:0] alm_min_nxt;
  logic [HOUR_W-1:0] alm_hour_r;
  logic [HOUR_W-1:0] alm_hour_nxt;
  logic [3:0] cmp_en_r;
  logic [3:0] cmp_en_nxt;

  logic alarm_flag_nxt;
  logic alarm_irq_nxt;
  logic read_freeze_nxt;
  logic write_freeze_nxt;
  logic osc_enable_nxt;
  rac_byte_t sfr_rdata_nxt;

  logic wr_ctl;
  logic both_freeze;
  logic alarm_set;
  logic match_hit;

  rac_cmp_if cmp_bus ();

  assign cmp_bus.alm_subsec = alm_subsec_r;
  assign cmp_bus.alm_sec = alm_sec_r;
  assign cmp_bus.alm_min = alm_min_r;
  assign cmp_bus.alm_hour = alm_hour_r;
  assign cmp_bus.now_subsec = clock_subsecond;
  assign cmp_bus.now_sec = clock_second;
  assign cmp_bus.now_min = clock_minute;
  assign cmp_bus.now_hour = clock_hour;
  assign cmp_bus.cmp_en = cmp_en_r;
  assign match_hit = cmp_bus.hit;

  rac_field_match u_match (
    .cmp(cmp_bus.cmp)
  );

  // The tick gates the evaluation, so a standing match fires once per
  // subsecond tick rather than on every clock.
  assign alarm_set = subsec_tick && match_hit;

  assign wr_ctl = sfr_wr && (sfr_addr == ADDR_CTL);
  assign both_freeze = sfr_wdata[CTL_READ_FRZ] && sfr_wdata[CTL_WRITE_FRZ];

  always_comb begin
    alm_subsec_nxt = alm_subsec_r;
    alm_sec_nxt = alm_sec_r;
    alm_min_nxt = alm_min_r;
    alm_hour_nxt = alm_hour_r;
    cmp_en_nxt = cmp_en_r;
    read_freeze_nxt = read_freeze_r;
    write_freeze_nxt = write_freeze_r;
    osc_enable_nxt = osc_enable_r;
    alarm_flag_nxt = alarm_flag_r;

    if (sfr_wr) begin
      case (sfr_addr)
        ADDR_ALM_SUBSEC: begin
          alm_subsec_nxt = sfr_wdata;
        end
        ADDR_ALM_SEC: begin
          alm_sec_nxt = sfr_wdata[SEC_W-1:0];
        end
        ADDR_ALM_MIN: begin
          alm_min_nxt = sfr_wdata[MIN_W-1:0];
        end
        ADDR_ALM_HOUR: begin
          alm_hour_nxt = sfr_wdata[HOUR_W-1:0];
        end
        default: begin
        end
      endcase
    end

    if (wr_ctl) begin
      cmp_en_nxt = sfr_wdata[CTL_SUBSEC_EN:CTL_HOUR_EN];
      // Asking for both freezes at once leaves both freeze bits unchanged; the rest of the write still acts.
      if (!both_freeze) begin
        read_freeze_nxt = sfr_wdata[CTL_READ_FRZ];
      end
      if (timed_access_ok) begin
        if (!both_freeze) begin
          write_freeze_nxt = sfr_wdata[CTL_WRITE_FRZ];
        end
        osc_enable_nxt = sfr_wdata[CTL_OSC];
      end
      // A written one is ignored; only a zero acts on the flag.
      if (!sfr_wdata[CTL_FLAG]) begin
        alarm_flag_nxt = 1'b0;
      end
      if (sfr_wdata[CTL_SUBSEC_EN:CTL_HOUR_EN] == EN_NONE) begin
        alarm_flag_nxt = 1'b0;
      end
    end

    // Set wins over any clear made in the same cycle.
    if (alarm_set) begin
      alarm_flag_nxt = 1'b1;
    end

    alarm_irq_nxt = alarm_flag_nxt && alarm_int_enable;
  end

  always_comb begin
    sfr_rdata_nxt = sfr_rdata_r;
    if (sfr_rd) begin
      case (sfr_addr)
        ADDR_ALM_SUBSEC: begin
          sfr_rdata_nxt = alm_subsec_r;
        end
        ADDR_ALM_SEC: begin
          sfr_rdata_nxt = {2'b00, alm_sec_r};
        end
        ADDR_ALM_MIN: begin
          sfr_rdata_nxt = {2'b00, alm_min_r};
        end
        ADDR_ALM_HOUR: begin
          sfr_rdata_nxt = {3'b000, alm_hour_r};
        end
        ADDR_CTL: begin
          sfr_rdata_nxt = {cmp_en_r, read_freeze_r, write_freeze_r,
                           alarm_flag_r, osc_enable_r};
        end
        default: begin
          sfr_rdata_nxt = RDATA_UNMAPPED;
        end
      endcase
    end
  end

  // Battery-backed state only answers to the no-battery reset; the ordinary
  // reset clears just the freeze bits and the read port.
  always_ff @(posedge clk) begin
    if (!bat_rst_n) begin
      alm_subsec_r <= BAT_RESET_VALUE;
      alm_sec_r <= BAT_RESET_VALUE[SEC_W-1:0];
      alm_min_r <= BAT_RESET_VALUE[MIN_W-1:0];
      alm_hour_r <= BAT_RESET_VALUE[HOUR_W-1:0];
      cmp_en_r <= EN_NONE;
      alarm_flag_r <= 1'b0;
      osc_enable_r <= 1'b0;
      alarm_irq_r <= 1'b0;
      read_freeze_r <= 1'b0;
      write_freeze_r <= 1'b0;
      sfr_rdata_r <= RDATA_RESET;
    end else begin
      alm_subsec_r <= alm_subsec_nxt;
      alm_sec_r <= alm_sec_nxt;
      alm_min_r <= alm_min_nxt;
      alm_hour_r <= alm_hour_nxt;
      cmp_en_r <= cmp_en_nxt;
      alarm_flag_r <= alarm_flag_nxt;
      osc_enable_r <= osc_enable_nxt;
      alarm_irq_r <= alarm_irq_nxt;
      if (!rst_n) begin
        read_freeze_r <= 1'b0;
        write_freeze_r <= 1'b0;
        sfr_rdata_r <= RDATA_RESET;
      end else begin
        read_freeze_r <= read_freeze_nxt;
        write_freeze_r <= write_freeze_nxt;
        sfr_rdata_r <= sfr_rdata_nxt;
      end
    end
  end

  property p_sub_match;
    @(posedge clk) disable iff (!rst_n || !bat_rst_n)
    (subsec_tick && cmp_en_r == 4'h8 && clock_subsecond == alm_subsec_r)
      |=> alarm_flag_r;
  endproperty
  a_sub_match: assert property (p_sub_match)
    else $error("subsecond match did not raise the alarm flag");

  property p_sec_miss;
    @(posedge clk) disable iff (!rst_n || !bat_rst_n)
    (subsec_tick && cmp_en_r == 4'h4 && clock_second != alm_sec_r
     && !alarm_flag_r) |=> !alarm_flag_r;
  endproperty
  a_sec_miss: assert property (p_sec_miss)
    else $error("second mismatch raised the alarm flag");

  property p_min_match;
    @(posedge clk) disable iff (!rst_n || !bat_rst_n)
    (subsec_tick && cmp_en_r == 4'h2 && clock_minute == alm_min_r)
      |=> alarm_flag_r;
  endproperty
  a_min_match: assert property (p_min_match)
    else $error("minute match did not raise the alarm flag");

  property p_hour_weekday;
    @(posedge clk) disable iff (!rst_n || !bat_rst_n)
    (subsec_tick && cmp_en_r == 4'h1 && clock_hour[4:0] == alm_hour_r
     && clock_hour[7:WEEKDAY_LSB] != 3'b000) |=> alarm_flag_r;
  endproperty
  a_hour_weekday: assert property (p_hour_weekday)
    else $error("weekday bits blocked an hour alarm");

  property p_set_cause;
    @(posedge clk) disable iff (!rst_n || !bat_rst_n)
    $rose(alarm_flag_r) |-> $past(subsec_tick) && $past(match_hit);
  endproperty
  a_set_cause: assert property (p_set_cause)
    else $error("alarm flag rose without a ticked full match");

  property p_ignore_hours;
    @(posedge clk) disable iff (!rst_n || !bat_rst_n)
    (subsec_tick && cmp_en_r == 4'hE && clock_subsecond == alm_subsec_r
     && clock_second == alm_sec_r && clock_minute == alm_min_r)
      |=> alarm_flag_r;
  endproperty
  a_ignore_hours: assert property (p_ignore_hours)
    else $error("hour field was not treated as don't care");

  property p_timed_only;
    @(posedge clk) disable iff (!rst_n || !bat_rst_n)
    (wr_ctl && !timed_access_ok) |=> $stable(write_freeze_r) && $stable(osc_enable_r);
  endproperty
  a_timed_only: assert property (p_timed_only)
    else $error("protected control bit changed without timed access");

  property p_reserved_zero;
    @(posedge clk) disable iff (!rst_n || !bat_rst_n)
    (sfr_rd && sfr_addr == ADDR_ALM_HOUR) |=> sfr_rdata_r[7:5] == 3'b000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved hour alarm bits read non-zero");

  property p_irq_follow;
    @(posedge clk) disable iff (!rst_n || !bat_rst_n)
    (alarm_flag_r && alarm_int_enable && !wr_ctl) |=> alarm_irq_r;
  endproperty
  a_irq_follow: assert property (p_irq_follow)
    else $error("enabled alarm flag did not request an interrupt");

  property p_en_clear;
    @(posedge clk) disable iff (!rst_n || !bat_rst_n)
    (wr_ctl && sfr_wdata[7:4] == 4'h0 && !alarm_set) |=> !alarm_flag_r;
  endproperty
  a_en_clear: assert property (p_en_clear)
    else $error("clearing all enables left the flag set");

  property p_keep_alarm;
    @(posedge clk) disable iff (!bat_rst_n)
    (!rst_n) |=> $stable(alm_subsec_r) && $stable(alm_hour_r) && $stable(cmp_en_r);
  endproperty
  a_keep_alarm: assert property (p_keep_alarm)
    else $error("ordinary reset disturbed battery-backed alarm state");

  // Only the tick may raise the flag, so a quiet cycle keeps it low.
  property p_quiet_between_ticks;
    @(posedge clk) disable iff (!rst_n || !bat_rst_n)
    (!subsec_tick && !alarm_flag_r) |=> !alarm_flag_r;
  endproperty
  a_quiet_between_ticks: assert property (p_quiet_between_ticks)
    else $error("alarm flag rose without a subsecond tick");

  property p_sw_never_sets;
    @(posedge clk) disable iff (!rst_n || !bat_rst_n)
    (wr_ctl && sfr_wdata[CTL_FLAG] && !subsec_tick && !alarm_flag_r) |=> !alarm_flag_r;
  endproperty
  a_sw_never_sets: assert property (p_sw_never_sets)
    else $error("software write set the alarm flag");

  property p_flag_holds;
    @(posedge clk) disable iff (!rst_n || !bat_rst_n)
    (alarm_flag_r && !wr_ctl) |=> alarm_flag_r;
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("alarm flag dropped without a control write");

  property p_irq_masked;
    @(posedge clk) disable iff (!rst_n || !bat_rst_n)
    (!alarm_int_enable) |=> !alarm_irq_r;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt requested while the alarm interrupt was disabled");

  property p_sub_dont_care;
    @(posedge clk) disable iff (!rst_n || !bat_rst_n)
    (subsec_tick && cmp_en_r == 4'h7 && clock_second == alm_sec_r && clock_minute == alm_min_r
     && clock_hour[HOUR_W-1:0] == alm_hour_r) |=> alarm_flag_r;
  endproperty
  a_sub_dont_care: assert property (p_sub_dont_care)
    else $error("disabled subsecond field blocked the alarm");

  // The freezes are the only control bits that the ordinary reset clears.
  property p_freeze_reset;
    @(posedge clk) disable iff (!bat_rst_n)
    (!rst_n) |=> !read_freeze_r && !write_freeze_r;
  endproperty
  a_freeze_reset: assert property (p_freeze_reset)
    else $error("ordinary reset left a freeze bit set");

endmodule

`default_nettype wire

//--- tb.sv
// Self-checking testbench for the alarm-compare block of the real-time clock.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rac_pkg::*;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic bat_rst_n = 1'b0;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic ta = 1'b0;
  logic tick = 1'b0;
  logic int_en = 1'b0;
  rac_byte_t addr = 8'h00;
  rac_byte_t wdata = 8'h00;
  rac_byte_t css = 8'h00;
  logic [5:0] cs = 6'h00;
  logic [5:0] cm = 6'h00;
  logic [7:0] ch = 8'h00;
  rac_byte_t rdata;
  logic flag;
  logic irq;
  logic rfz;
  logic wfz;
  logic osc;
  int num_errors = 0;
  int cmp_count = 0;

  rac_alarm dut (
    .clk(clk),
    .rst_n(rst_n),
    .bat_rst_n(bat_rst_n),
    .sfr_addr(addr),
    .sfr_wr(sfr_wr),
    .sfr_wdata(wdata),
    .sfr_rd(sfr_rd),
    .timed_access_ok(ta),
    .clock_subsecond(css),
    .clock_second(cs),
    .clock_minute(cm),
    .clock_hour(ch),
    .subsec_tick(tick),
    .alarm_int_enable(int_en),
    .sfr_rdata_r(rdata),
    .alarm_flag_r(flag),
    .alarm_irq_r(irq),
    .read_freeze_r(rfz),
    .write_freeze_r(wfz),
    .osc_enable_r(osc)
  );

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic conclude();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input rac_byte_t got, input rac_byte_t exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Inputs move on the falling edge; each strobe gets a quiet cycle after it.
  task automatic wr(input rac_byte_t a, input rac_byte_t d, input logic t);
    @(negedge clk);
    addr = a;
    wdata = d;
    ta = t;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    ta = 1'b0;
  endtask

  task automatic rd_chk(input rac_byte_t a, input rac_byte_t exp);
    @(negedge clk);
    addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    chk(rdata, exp);
  endtask

  task automatic tick_chk(input logic exp);
    @(negedge clk);
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    chk({7'h00, flag}, {7'h00, exp});
    chk({7'h00, irq}, {7'h00, exp & int_en});
  endtask

  // Bit 3 of miss spoils the subsecond, bit 0 the hour; weekday bits stay non-zero.
  task automatic set_time(input logic [3:0] miss);
    css = 8'h10 ^ {7'h00, miss[3]};
    cs = 6'h2A ^ {5'h00, miss[2]};
    cm = 6'h3B ^ {5'h00, miss[1]};
    ch = 8'hB7 ^ {7'h00, miss[0]};
  endtask

  task automatic t_reset();
    rd_chk(ADDR_ALM_SUBSEC, 8'h00);
    rd_chk(ADDR_ALM_SEC, 8'h00);
    rd_chk(ADDR_ALM_MIN, 8'h00);
    rd_chk(ADDR_ALM_HOUR, 8'h00);
    rd_chk(ADDR_CTL, 8'h00);
  endtask

  task automatic t_regs();
    wr(ADDR_ALM_SUBSEC, 8'hA5, 1'b0);
    wr(ADDR_ALM_SEC, 8'hFF, 1'b0);
    wr(ADDR_ALM_MIN, 8'hFF, 1'b0);
    wr(ADDR_ALM_HOUR, 8'hFF, 1'b0);
    rd_chk(ADDR_ALM_SUBSEC, 8'hA5);
    rd_chk(ADDR_ALM_SEC, 8'h3F);
    rd_chk(ADDR_ALM_MIN, 8'h3F);
    rd_chk(ADDR_ALM_HOUR, 8'h1F);
    // The held read data is non-zero here, so a dead unmapped decode shows.
    rd_chk(8'hF7, RDATA_UNMAPPED);
    wr(ADDR_ALM_SUBSEC, 8'h10, 1'b0);
    wr(ADDR_ALM_SEC, 8'h2A, 1'b0);
    wr(ADDR_ALM_MIN, 8'h3B, 1'b0);
    wr(ADDR_ALM_HOUR, 8'h17, 1'b0);
  endtask

  task automatic t_ctl();
    wr(ADDR_CTL, 8'h08, 1'b0);
    chk({7'h00, rfz}, 8'h01);
    wr(ADDR_CTL, 8'h0C, 1'b1);
    chk({6'h00, rfz, wfz}, 8'h02);
    wr(ADDR_CTL, 8'h05, 1'b0);
    chk({5'h00, rfz, wfz, osc}, 8'h00);
    wr(ADDR_CTL, 8'h05, 1'b1);
    chk({5'h00, rfz, wfz, osc}, 8'h03);
    wr(ADDR_CTL, 8'h01, 1'b1);
    wr(ADDR_CTL, 8'h02, 1'b0);
    rd_chk(ADDR_CTL, 8'h01);
  endtask

  task automatic t_match();
    int_en = 1'b1;
    wr(ADDR_CTL, 8'hF0, 1'b0);
    set_time(4'h0);
    repeat (3) @(negedge clk);
    chk({7'h00, flag}, 8'h00);
    tick_chk(1'b1);
    wr(ADDR_CTL, 8'hF0, 1'b0);
    chk({7'h00, flag}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      int_en = i[0];
      set_time(4'h8 >> i);
      tick_chk(1'b0);
      wr(ADDR_CTL, 8'hF0 & ~(8'h80 >> i), 1'b0);
      tick_chk(1'b1);
      wr(ADDR_CTL, 8'hF0 & ~(8'h80 >> i), 1'b0);
    end
  endtask

  task automatic t_clear();
    int_en = 1'b1;
    wr(ADDR_CTL, 8'hF0, 1'b0);
    set_time(4'h0);
    tick_chk(1'b1);
    wr(ADDR_CTL, 8'h00, 1'b0);
    chk({7'h00, flag}, 8'h00);
    tick_chk(1'b0);
    wr(ADDR_ALM_SUBSEC, SUBSEC_MAX, 1'b0);
    wr(ADDR_CTL, 8'h80, 1'b0);
    css = 8'hFF;
    tick_chk(1'b1);
    wr(ADDR_ALM_SUBSEC, 8'h10, 1'b0);
  endtask

  // One field enabled at a time: a miss keeps the flag low, a hit raises it.
  task automatic t_single();
    for (int j = 0; j < 3; j++) begin
      wr(ADDR_CTL, 8'h40 >> j, 1'b0);
      set_time(4'h4 >> j);
      tick_chk(1'b0);
      set_time(4'h0);
      tick_chk(1'b1);
    end
  endtask

  // An ordinary reset must leave the alarm state alone and drop only the freezes and the read data.
  task automatic t_warm();
    wr(ADDR_CTL, 8'hF8, 1'b0);
    set_time(4'h0);
    tick_chk(1'b1);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd_chk(ADDR_ALM_SUBSEC, 8'h10);
    rd_chk(ADDR_ALM_SEC, 8'h2A);
    rd_chk(ADDR_ALM_MIN, 8'h3B);
    rd_chk(ADDR_ALM_HOUR, 8'h17);
    rd_chk(ADDR_CTL, 8'hF3);
  endtask

  initial begin
    #200000;
    num_errors++;
    conclude();
  end

  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    bat_rst_n = 1'b1;
    t_reset();
    t_regs();
    t_ctl();
    t_match();
    t_clear();
    t_single();
    t_warm();
    conclude();
  end
endmodule

`default_nettype wire
